// ===== verilog/flash_self_program_writer.v
// Flash self-programming sequencer: pointer, holding buffer, unlock and long write
`include "flash_writer_defs.vh"

// Behaviour
// - Unlocked write-start programs from holding registers
// - CPU stalled for whole long write
// - Write enable bit 2 gates any write
// - Reset during write sets write error flag
// - Control bits: erase 4, error 3, enable 2, start 1
// - Unimplemented bits read as zero
// - Unlock register is not storage, feeds detection
// - Pointer split low, high, upper with bit 21
// - Erase select makes write-start erase the block
// - Erase uses pointer bits 21 to 10 only
// - Holding registers keep contents after a write
// - Internal timer ends each long cycle
module flash_self_program_writer #(
  parameter PROG_CYCLES  = `PROG_WRITE_CYCLES, // Long write duration in clocks
  parameter ERASE_CYCLES = `ERASE_CYCLES       // Block erase duration in clocks
) (
  input  wire        sys_clk,
  input  wire        arst_n,
  input  wire        master_reset_evt,
  input  wire        watchdog_timer_evt,
  input  wire        sfr_wr,
  input  wire [7:0]  sfr_addr,
  input  wire [7:0]  sfr_wdata,
  output reg  [7:0]  sfr_rdata,
  input  wire        tbl_wr,
  input  wire        tbl_rd,
  input  wire [1:0]  tbl_mode,
  output reg         cpu_stall,
  output reg  [21:0] flash_addr,
  output reg  [7:0]  flash_wdata,
  output reg         flash_prog_we,
  output reg         flash_erase,
  output reg         flash_rd,
  input  wire [7:0]  flash_rd_data
);

  // One-hot sequencer states
  localparam [2:0] S_IDLE  = 3'h1; // Waiting for an unlocked start
  localparam [2:0] S_LOAD  = 3'h2; // Streaming holding bytes to the array
  localparam [2:0] S_TIMED = 3'h4; // Programming timer running

  reg [7:0]  hold_mem [0:`HOLD_BYTES-1]; // Holding buffer, never cleared
  reg [21:0] table_pointer;              // Byte pointer into program space
  reg [7:0]  table_latch;                // Table read and write data byte
  reg [7:0]  interrupt_control;          // Interrupt control storage
  reg        erase_select;               // Erase instead of program
  reg        write_error_flag;           // Long write was cut by a reset
  reg        write_enable_bit;           // Software write permission
  reg        write_start;                // Long cycle requested or running
  reg        key_first_seen;             // First key just written
  reg        key_armed;                  // Both keys just written
  reg [2:0]  state;                      // Sequencer state
  reg [`HOLD_IDX_BITS-1:0] load_idx;     // Holding byte being streamed
  reg [31:0] timer;                      // Programming timer
  reg        rd_pending;                 // Table read data due this cycle

  // Decoded access strobes
  wire wr_ctrl  = sfr_wr && (sfr_addr == `ADDR_FLASH_CONTROL);
  wire wr_key   = sfr_wr && (sfr_addr == `ADDR_FLASH_UNLOCK_KEY);
  wire tbl_any  = tbl_wr || tbl_rd;
  wire cut_evt  = master_reset_evt || watchdog_timer_evt;
  wire busy     = !state[0];
  wire start_req = wr_ctrl && sfr_wdata[`FC_WRITE_START_BIT] && !busy;

  // Pointer value used by a table access and after it
  reg [21:0] access_ptr;
  reg [21:0] next_ptr;
  always @* begin
    access_ptr = table_pointer;
    next_ptr   = table_pointer;
    if (tbl_mode == `TBL_MODE_PRE_INC) begin
      access_ptr = table_pointer + 22'h000001;
      next_ptr   = access_ptr;
    end else if (tbl_mode == `TBL_MODE_POST_INC) begin
      next_ptr = table_pointer + 22'h000001;
    end else if (tbl_mode == `TBL_MODE_POST_DEC) begin
      next_ptr = table_pointer - 22'h000001;
    end
  end

  // Start is accepted only with enable set and keys fresh
  wire next_enable = wr_ctrl ? sfr_wdata[`FC_WRITE_ENABLE_BIT] : write_enable_bit;
  wire start_ok    = start_req && key_armed && next_enable;
  // Erase select as it stands after this cycle's control write
  wire next_erase  = wr_ctrl ? sfr_wdata[`FC_ERASE_SELECT_BIT] : erase_select;

  // Holding buffer writes, no reset so stale data survives
  always @(posedge sys_clk) begin
    if (tbl_wr && !busy) begin
      hold_mem[access_ptr[`HOLD_IDX_BITS-1:0]] <= table_latch;
    end
  end

  // Unlock key detection, any other register write or table access breaks the chain
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      key_first_seen <= 1'b0;
      key_armed      <= 1'b0;
    end else if (cut_evt) begin
      key_first_seen <= 1'b0;
      key_armed      <= 1'b0;
    end else if (wr_key) begin
      key_first_seen <= (sfr_wdata == `UNLOCK_KEY_FIRST);
      key_armed      <= key_first_seen && (sfr_wdata == `UNLOCK_KEY_SECOND);
    end else if (sfr_wr || tbl_any) begin
      key_first_seen <= 1'b0;
      key_armed      <= 1'b0;
    end
  end

  // Software-visible registers and table accesses
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      table_pointer     <= `RESET_POINTER;
      table_latch       <= `RESET_BYTE;
      interrupt_control <= `RESET_BYTE;
      erase_select      <= 1'b0;
      write_enable_bit  <= 1'b0;
      write_error_flag  <= 1'b0;
      rd_pending        <= 1'b0;
    end else begin
      rd_pending <= 1'b0;
      // Reset cut into a long cycle, error set wins over clear
      if (cut_evt && busy) begin
        write_error_flag <= 1'b1;
      end else if (wr_ctrl) begin
        write_error_flag <= sfr_wdata[`FC_WRITE_ERROR_BIT];
      end
      if (cut_evt) begin
        write_enable_bit <= 1'b0;
        erase_select     <= 1'b0;
      end else if (wr_ctrl) begin
        erase_select     <= sfr_wdata[`FC_ERASE_SELECT_BIT];
        write_enable_bit <= sfr_wdata[`FC_WRITE_ENABLE_BIT];
      end
      if (sfr_wr && !busy) begin
        // Pointer bytes, upper byte holds bits 21 to 16
        if (sfr_addr == `ADDR_TABLE_POINTER_UPPER) begin
          table_pointer[21:16] <= sfr_wdata[5:0];
        end else if (sfr_addr == `ADDR_TABLE_POINTER_HIGH) begin
          table_pointer[15:8] <= sfr_wdata;
        end else if (sfr_addr == `ADDR_TABLE_POINTER_LOW) begin
          table_pointer[7:0] <= sfr_wdata;
        end else if (sfr_addr == `ADDR_TABLE_LATCH) begin
          table_latch <= sfr_wdata;
        end else if (sfr_addr == `ADDR_INTERRUPT_CONTROL) begin
          interrupt_control <= sfr_wdata;
        end
      end else if (tbl_any && !busy) begin
        // Table access moves the pointer per mode
        table_pointer <= next_ptr;
        rd_pending    <= tbl_rd;
      end
      if (rd_pending) begin
        table_latch <= flash_rd_data;
      end
    end
  end

  // Long write and erase sequencer with its timer
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state         <= S_IDLE;
      write_start   <= 1'b0;
      load_idx      <= {`HOLD_IDX_BITS{1'b0}};
      timer         <= 32'h00000000;
      cpu_stall     <= 1'b0;
      flash_addr    <= `RESET_POINTER;
      flash_wdata   <= `RESET_BYTE;
      flash_prog_we <= 1'b0;
      flash_erase   <= 1'b0;
      flash_rd      <= 1'b0;
    end else begin
      flash_prog_we <= 1'b0;
      flash_erase   <= 1'b0;
      flash_rd      <= 1'b0;
      if (cut_evt) begin
        // Reset aborts any cycle in flight
        state       <= S_IDLE;
        write_start <= 1'b0;
        cpu_stall   <= 1'b0;
      end else begin
        case (state)
          S_IDLE: begin
            if (tbl_rd) begin
              // Table read address goes out to the array
              flash_addr <= access_ptr;
              flash_rd   <= 1'b1;
            end
            if (start_ok && next_erase) begin
              // Block erase ignores the low ten pointer bits
              flash_addr  <= {table_pointer[21:`ERASE_LSB_BITS],
                              {`ERASE_LSB_BITS{1'b0}}};
              flash_erase <= 1'b1;
              timer       <= ERASE_CYCLES - 1;
              write_start <= 1'b1;
              cpu_stall   <= 1'b1;
              state       <= S_TIMED;
            end else if (start_ok) begin
              write_start <= 1'b1;
              cpu_stall   <= 1'b1;
              load_idx    <= {`HOLD_IDX_BITS{1'b0}};
              state       <= S_LOAD;
            end
          end
          S_LOAD: begin
            // Stream one holding byte per clock into the addressed row
            flash_addr    <= {table_pointer[21:`HOLD_IDX_BITS], load_idx};
            flash_wdata   <= hold_mem[load_idx];
            flash_prog_we <= 1'b1;
            load_idx      <= load_idx + 1'b1;
            if (load_idx == `HOLD_BYTES - 1) begin
              timer <= PROG_CYCLES - 1;
              state <= S_TIMED;
            end
          end
          S_TIMED: begin
            // Timer ends the long cycle and releases the CPU
            if (timer == 32'h00000000) begin
              write_start <= 1'b0;
              cpu_stall   <= 1'b0;
              state       <= S_IDLE;
            end else begin
              timer <= timer - 32'h00000001;
            end
          end
          default: begin
            state <= S_IDLE;
          end
        endcase
      end
    end
  end

  // Registered read data, unimplemented bits and key register read zero
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sfr_rdata <= `RESET_BYTE;
    end else if (sfr_addr == `ADDR_TABLE_POINTER_UPPER) begin
      sfr_rdata <= {2'h0, table_pointer[21:16]};
    end else if (sfr_addr == `ADDR_TABLE_POINTER_HIGH) begin
      sfr_rdata <= table_pointer[15:8];
    end else if (sfr_addr == `ADDR_TABLE_POINTER_LOW) begin
      sfr_rdata <= table_pointer[7:0];
    end else if (sfr_addr == `ADDR_TABLE_LATCH) begin
      sfr_rdata <= table_latch;
    end else if (sfr_addr == `ADDR_INTERRUPT_CONTROL) begin
      sfr_rdata <= interrupt_control;
    end else if (sfr_addr == `ADDR_FLASH_CONTROL) begin
      sfr_rdata <= {3'h0, erase_select, write_error_flag,
                    write_enable_bit, write_start, 1'b0};
    end else begin
      sfr_rdata <= `RESET_BYTE;
    end
  end

endmodule // flash_self_program_writer

// ===== common/flash_writer_defs.vh
// Constants for the flash self-programming write sequencer
`ifndef FLASH_WRITER_DEFS_VH
`define FLASH_WRITER_DEFS_VH

// Special function register addresses on the CPU register port
`define ADDR_TABLE_POINTER_UPPER 8'hF8
`define ADDR_TABLE_POINTER_HIGH  8'hF7
`define ADDR_TABLE_POINTER_LOW   8'hF6
`define ADDR_TABLE_LATCH         8'hF5
`define ADDR_INTERRUPT_CONTROL   8'hF2
`define ADDR_FLASH_UNLOCK_KEY    8'hA7
`define ADDR_FLASH_CONTROL       8'hA6

// Flash control field positions
`define FC_ERASE_SELECT_BIT 4
`define FC_WRITE_ERROR_BIT  3
`define FC_WRITE_ENABLE_BIT 2
`define FC_WRITE_START_BIT  1

// Unlock keys
`define UNLOCK_KEY_FIRST  8'h55
`define UNLOCK_KEY_SECOND 8'hAA

// Table operation modes
`define TBL_MODE_PLAIN    2'h0
`define TBL_MODE_POST_INC 2'h1
`define TBL_MODE_POST_DEC 2'h2
`define TBL_MODE_PRE_INC  2'h3

// Reset values
`define RESET_BYTE    8'h00
`define RESET_POINTER 22'h000000

// Holding buffer and erase block geometry
`define HOLD_BYTES     64
`define HOLD_IDX_BITS  6
`define ERASE_LSB_BITS 10

// Timing: programming and erase times in nanoseconds, clock period in ns
`define CLK_PERIOD_NS      10
`define PROG_WRITE_TIME_NS 1000000
`define ERASE_TIME_NS      1000000
`define PROG_WRITE_CYCLES  (`PROG_WRITE_TIME_NS / `CLK_PERIOD_NS)
`define ERASE_CYCLES       (`ERASE_TIME_NS / `CLK_PERIOD_NS)

`endif

// ===== test/flash_writer_props.sv
// Port checker for the flash self-programming sequencer
`include "flash_writer_defs.vh"
module flash_writer_props (
  input wire        sys_clk,
  input wire        arst_n,
  input wire        master_reset_evt,
  input wire        watchdog_timer_evt,
  input wire        sfr_wr,
  input wire [7:0]  sfr_addr,
  input wire [7:0]  sfr_wdata,
  input wire [7:0]  sfr_rdata,
  input wire        tbl_rd,
  input wire        cpu_stall,
  input wire [21:0] flash_addr,
  input wire        flash_prog_we,
  input wire        flash_erase,
  input wire        flash_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  AST_PROG_STALL: assert property (flash_prog_we |-> cpu_stall)
    else $error("program pulse outside stall");
  AST_ERASE_BLOCK: assert property (
    flash_erase |-> cpu_stall && flash_addr[9:0] == 10'h000)
    else $error("erase address not block aligned");
  AST_START_CAUSE: assert property ($rose(cpu_stall) |->
    $past(sfr_wr && sfr_addr == `ADDR_FLASH_CONTROL && sfr_wdata[2:1] == 2'h3))
    else $error("stall without enabled start write");
  AST_START_ACTION: assert property ($rose(cpu_stall) |=>
    flash_prog_we || $past(flash_erase))
    else $error("stall without erase or program");
  AST_EVT_ABORT: assert property (
    master_reset_evt || watchdog_timer_evt |=> !cpu_stall)
    else $error("reset event did not end stall");
  AST_ROW_BASE: assert property ($rose(flash_prog_we) |-> flash_addr[5:0] == 6'h00)
    else $error("row stream not at row base");
  AST_ROW_STEP: assert property (flash_prog_we ##1 flash_prog_we |->
    flash_addr == $past(flash_addr) + 22'h1)
    else $error("row stream address skipped");
  AST_TIMER_END: assert property ($rose(cpu_stall) |-> ##[20:100] !cpu_stall)
    else $error("long cycle did not end");
  AST_KEY_READ: assert property (
    $past(sfr_addr) == `ADDR_FLASH_UNLOCK_KEY |-> sfr_rdata == 8'h00)
    else $error("unlock register read not zero");
  AST_CTRL_READ: assert property (
    $past(sfr_addr) == `ADDR_FLASH_CONTROL |-> sfr_rdata[7:5] == 3'h0 && !sfr_rdata[0])
    else $error("unimplemented control bits set");
  AST_READ_PULSE: assert property (tbl_rd && !cpu_stall |=> flash_rd)
    else $error("table read gave no array read");
endmodule // flash_writer_props
bind flash_self_program_writer flash_writer_props i_props (.*);

// ===== test/flash_array_model.sv
// Behavioural program memory array beside the sequencer
module flash_array_model (
  input  wire        sys_clk,
  input  wire [21:0] flash_addr,
  input  wire [7:0]  flash_wdata,
  input  wire        flash_prog_we,
  input  wire        flash_erase,
  input  wire        flash_rd,
  output logic [7:0] flash_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:1023]; // One erase block, aliased over the space
  // Erase and program on the clock edge
  always @(posedge sys_clk) begin
    if (flash_erase) begin
      for (int i = 0; i < 1024; i++)
        mem[i] <= 8'hFF;
    end
    if (flash_prog_we) begin
      mem[flash_addr[9:0]] <= flash_wdata;
    end
  end
  // Read data stands while the read strobe is high, taken at the edge ending it
  // Otherwise the inverse, so stale data never passes for valid
  assign flash_rd_data = flash_rd ? mem[flash_addr[9:0]] : ~mem[flash_addr[9:0]];
endmodule // flash_array_model

// ===== test/test_flash_self_program_writer.sv
// Self-checking bench for the flash self-programming sequencer
`include "flash_writer_defs.vh"
module test_flash_self_program_writer;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        master_reset_evt = 1'b0;
  logic        watchdog_timer_evt = 1'b0;
  logic        sfr_wr = 1'b0;
  logic [7:0]  sfr_addr = 8'h00;
  logic [7:0]  sfr_wdata = 8'h00;
  logic        tbl_wr = 1'b0;
  logic        tbl_rd = 1'b0;
  logic [1:0]  tbl_mode = 2'h0;
  wire  [7:0]  sfr_rdata;
  wire         cpu_stall;
  wire  [21:0] flash_addr;
  wire  [7:0]  flash_wdata;
  wire         flash_prog_we;
  wire         flash_erase;
  wire         flash_rd;
  wire  [7:0]  flash_rd_data;
  int          errors = 0;
  int          n_tests = 0;
  int          cyc = 0;
  logic [7:0]  rd; // Last register read
  flash_self_program_writer #(.PROG_CYCLES(20), .ERASE_CYCLES(20)) i_dut (.*);
  flash_array_model i_flash (.*);
  initial forever #5 sys_clk = ~sys_clk;
  // Hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      errors++;
    end
  endtask
  task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge sys_clk);
    sfr_wr = 1'b0;
  endtask
  task automatic sfr_r(input logic [7:0] a);
    @(negedge sys_clk);
    sfr_addr = a;
    @(negedge sys_clk);
    rd = sfr_rdata;
  endtask
  task automatic tbl(input logic w, input logic [1:0] m);
    @(negedge sys_clk);
    tbl_mode = m;
    tbl_wr = w;
    tbl_rd = !w;
    @(negedge sys_clk);
    tbl_wr = 1'b0;
    tbl_rd = 1'b0;
  endtask
  // Data pattern for byte n of the rewritten block
  function automatic logic [7:0] pat(input int n);
    return 8'(n) ^ 8'(n >> 8);
  endfunction
  // Table read, then fetch the latch once the array byte has landed
  task automatic tbl_read(input logic [1:0] m);
    tbl(1'b0, m);
    repeat (2) @(negedge sys_clk);
    sfr_r(`ADDR_TABLE_LATCH);
  endtask
  task automatic start_op(input logic [7:0] c);
    sfr_w(`ADDR_INTERRUPT_CONTROL, 8'h00);
    sfr_w(`ADDR_FLASH_UNLOCK_KEY, `UNLOCK_KEY_FIRST);
    sfr_w(`ADDR_FLASH_UNLOCK_KEY, `UNLOCK_KEY_SECOND);
    sfr_w(`ADDR_FLASH_CONTROL, c);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (cpu_stall !== 1'b0 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    chk({7'h0, cpu_stall}, 8'h00);
  endtask
  task automatic test_regs();
    sfr_r(`ADDR_FLASH_CONTROL);
    chk(rd, `RESET_BYTE);
    sfr_w(`ADDR_FLASH_CONTROL, 8'hFF);
    sfr_r(`ADDR_FLASH_CONTROL);
    chk(rd, 8'h1C);
    sfr_w(`ADDR_FLASH_UNLOCK_KEY, `UNLOCK_KEY_FIRST);
    sfr_w(`ADDR_TABLE_POINTER_LOW, 8'h12);
    sfr_w(`ADDR_FLASH_UNLOCK_KEY, `UNLOCK_KEY_SECOND);
    sfr_w(`ADDR_FLASH_CONTROL, 8'h06);
    chk({7'h0, cpu_stall}, 8'h00);
    sfr_w(`ADDR_FLASH_CONTROL, 8'h00);
    start_op(8'h02);
    sfr_r(`ADDR_FLASH_CONTROL);
    chk(rd, 8'h00);
    sfr_w(`ADDR_TABLE_POINTER_UPPER, 8'hFF);
    sfr_r(`ADDR_TABLE_POINTER_UPPER);
    chk(rd, 8'h3F);
    sfr_r(`ADDR_FLASH_UNLOCK_KEY);
    chk(rd, 8'h00);
    $display("test_regs done");
  endtask
  task automatic test_erase();
    sfr_w(`ADDR_TABLE_POINTER_UPPER, 8'h00);
    sfr_w(`ADDR_TABLE_POINTER_HIGH, 8'h06);
    sfr_w(`ADDR_TABLE_POINTER_LOW, 8'hA5);
    sfr_w(`ADDR_FLASH_CONTROL, 8'h14);
    start_op(8'h16);
    chk({7'h0, cpu_stall}, 8'h01);
    wait_idle();
    tbl_read(`TBL_MODE_PLAIN);
    chk(rd, 8'hFF);
    $display("test_erase done");
  endtask
  task automatic test_program();
    sfr_w(`ADDR_TABLE_POINTER_HIGH, 8'h03);
    sfr_w(`ADDR_TABLE_POINTER_LOW, 8'hFF);
    for (int c = 0; c < 16; c++) begin
      for (int i = 0; i < 64; i++) begin
        sfr_w(`ADDR_TABLE_LATCH, pat(c * 64 + i));
        tbl(1'b1, `TBL_MODE_PRE_INC);
      end
      sfr_w(`ADDR_FLASH_CONTROL, 8'h04);
      start_op(8'h06);
      sfr_r(`ADDR_FLASH_CONTROL);
      chk(rd, 8'h06);
      chk({7'h0, cpu_stall}, 8'h01);
      wait_idle();
      sfr_r(`ADDR_FLASH_CONTROL);
      chk(rd, 8'h04);
      sfr_w(`ADDR_FLASH_CONTROL, 8'h00);
    end
    sfr_w(`ADDR_TABLE_POINTER_HIGH, 8'h04);
    sfr_w(`ADDR_TABLE_POINTER_LOW, 8'h00);
    for (int i = 0; i < 1024; i++) begin
      tbl_read(`TBL_MODE_POST_INC);
      chk(rd, pat(i));
    end
    $display("test_program done");
  endtask
  task automatic test_abort();
    for (int k = 0; k < 2; k++) begin
      sfr_w(`ADDR_FLASH_CONTROL, 8'h04);
      start_op(8'h06);
      repeat (20) @(negedge sys_clk);
      watchdog_timer_evt = (k == 0);
      master_reset_evt = (k == 1);
      @(negedge sys_clk);
      watchdog_timer_evt = 1'b0;
      master_reset_evt = 1'b0;
      chk({7'h0, cpu_stall}, 8'h00);
      sfr_r(`ADDR_FLASH_CONTROL);
      chk(rd, 8'h08);
      sfr_w(`ADDR_FLASH_CONTROL, 8'h00);
    end
    sfr_w(`ADDR_FLASH_CONTROL, 8'h04);
    start_op(8'h06);
    wait_idle();
    tbl_read(`TBL_MODE_PLAIN);
    chk(rd, pat(960));
    $display("test_abort done");
  endtask
  task automatic report_and_stop();
    $display("tests=%0d errors=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence: reset, then erase before programming
  initial begin
    repeat (8) @(negedge sys_clk);
    arst_n = 1'b1;
    test_regs();
    test_erase();
    test_program();
    test_abort();
    report_and_stop();
  end
endmodule // test_flash_self_program_writer
